// ### src/ctcp_regs.svh
`ifndef CTCP_REGS_SVH
`define CTCP_REGS_SVH

// register byte offsets on the apb bus
`define CTCP_OFS_CTRL0 8'h00
`define CTCP_OFS_CTRL1 8'h04
`define CTCP_OFS_CNT_LO 8'h08
`define CTCP_OFS_CNT_HI 8'h0C
`define CTCP_OFS_CMPA_LO 8'h10
`define CTCP_OFS_CMPA_HI 8'h14
`define CTCP_OFS_FLAGS 8'h18

// field positions
`define CTCP_FLAG_A_BIT 0
`define CTCP_FLAG_P_BIT 1
`define CTCP_HI_BYTE_W 2

// reset values
`define CTCP_CTRL0_RST 8'h00
`define CTCP_CTRL1_RST 8'h00
`define CTCP_CMPA_RST 10'h000
`define CTCP_CNT_RST 10'h000

// timing counts, in timer clocks
`define CTCP_CNT_MAX 10'h3FF
`define CTCP_FULL_LEN 11'h400

`endif

// ### src/ctcp_pkg.sv
package ctcp_pkg;

  // operating mode field encodings
  typedef enum logic [1:0] {
    CTCP_MODE_CMP = 2'h0,
    CTCP_MODE_UNDEF = 2'h1,
    CTCP_MODE_PWM = 2'h2,
    CTCP_MODE_TMR = 2'h3
  } ctcp_mode_t;

  // first control byte: spare holds pause and clock-select storage only
  typedef struct packed {
    logic [3:0] spare;
    logic timer_enable_bit;
    logic [2:0] period_code;
  } ctcp_ctrl0_t;

  // second control byte
  typedef struct packed {
    ctcp_mode_t mode;
    logic [1:0] pin_action;
    logic output_control_bit;
    logic output_invert_bit;
    logic period_duty_swap_bit;
    logic clear_select_bit;
  } ctcp_ctrl1_t;

endpackage : ctcp_pkg

// ### src/ctcp_timer.sv
// Functional notes
// - invert bit flips the output pin; no effect in timer/counter mode
// - pwm swap bit picks which comparator sets period and which duty
// - clear-select 1 clears on A match, 0 on P match or overflow
// - overflow clearing only with period code zero and clear-select 0, or swap 0 in pwm
// - pwm mode ignores clear-select; swap bit alone picks clear source
// - 10-bit counter readable as low byte and two-bit high byte
// - 10-bit compare A value read/write as low and high bytes
// - unused high byte bits 7 to 2 always read zero
// - mode field: 00 compare output, 11 timer/counter, 10 pwm
// - compare mode with clear-select 0 raises both match flags
// - outside pwm mode, clear-select 1 raises only the A flag, never P
// - compare A zero: no A match or flag; with A as clear source the counter wraps at 3FF
// - compare mode pin changes only on A match, not P
// - enable rise loads pin initial level; action 00 leaves pin alone
// - timer/counter mode counts like compare mode, pin not driven
// - pwm: one comparator clears period, other sets duty, both flag
// - swap 0: period from code in 128 steps, 000 gives 1024
// - duty at or above period holds output active all period
// - swap 1: period from compare A, duty from code steps
// - pwm: output-control picks polarity, action enables or forces pin
// - pwm counting continues while pin is forced by action 00 or 01
// - pwm action: 00 inactive, 01 active, 10 waveform, 11 undefined
// - enable rise zeroes counter; enable fall freezes it
// - period code compares only against counter bits 9 to 7
`timescale 1ns/1ps
`include "ctcp_regs.svh"

module ctcp_timer
  import ctcp_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // timer clock, one-cycle tick from the clock selector
  input wire logic i_timer_tick,
  // output pin
  output logic o_timer_output_pin,
  output logic o_timer_output_pin_oe,
  // match events
  output logic o_compare_a_match,
  output logic o_compare_p_match
);

  // reset release through two flops
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // state
  ctcp_ctrl0_t ctrl0;
  ctcp_ctrl1_t ctrl1;
  logic [9:0] cnt;
  logic [9:0] cmpa;
  logic en_q;
  logic pin_lvl;
  logic flag_a;
  logic flag_p;
  logic [31:0] prdata;
  logic pin_out;
  logic pin_oe;
  logic a_pulse;
  logic p_pulse;

  // next values
  ctcp_ctrl0_t next_ctrl0;
  ctcp_ctrl1_t next_ctrl1;
  logic [9:0] next_cnt;
  logic [9:0] next_cmpa;
  logic next_en_q;
  logic next_pin_lvl;
  logic next_flag_a;
  logic next_flag_p;
  logic [31:0] next_prdata;
  logic next_pin_out;
  logic next_pin_oe;

  // decode helpers
  logic wr;
  logic rd_setup;
  logic addr_ok;
  logic is_pwm;
  logic is_cmp;
  logic pin_used;
  logic en_rise;
  logic run;
  logic [9:0] cnt_inc;
  logic code_zero;
  logic a_hit;
  logic p_hit;
  logic clear_on_a;
  logic clr;
  logic set_p;
  logic [10:0] code_len;
  logic [10:0] cmpa_len;
  logic [10:0] duty_len;
  logic [10:0] period_len;
  logic pwm_active;
  logic pwm_lvl;
  logic out_lvl;

  // bus decode; zero wait states, so ready is simply high
  always_comb begin
    wr = i_psel & i_penable & i_pwrite;
    rd_setup = i_psel & ~i_penable & ~i_pwrite;
    unique case (i_paddr)
      `CTCP_OFS_CTRL0, `CTCP_OFS_CTRL1, `CTCP_OFS_CNT_LO, `CTCP_OFS_CNT_HI,
      `CTCP_OFS_CMPA_LO, `CTCP_OFS_CMPA_HI, `CTCP_OFS_FLAGS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~addr_ok;

  // counter and comparators
  always_comb begin
    is_pwm = (ctrl1.mode == CTCP_MODE_PWM);
    is_cmp = (ctrl1.mode == CTCP_MODE_CMP);
    pin_used = is_pwm | is_cmp;
    en_rise = ctrl0.timer_enable_bit & ~en_q;
    // counting only once the enable edge has been seen, so the zeroing wins
    run = ctrl0.timer_enable_bit & en_q & i_timer_tick;
    cnt_inc = cnt + 10'h001;
    code_zero = (ctrl0.period_code == 3'h0);
    // matches are judged on the value the tick would produce
    a_hit = run & (cmpa != 10'h000) & (cnt_inc == cmpa);
    if (code_zero) begin
      p_hit = run & (cnt == `CTCP_CNT_MAX);
    end else begin
      p_hit = run & (cnt_inc[9:7] == ctrl0.period_code)
              & (cnt[9:7] != ctrl0.period_code);
    end
    clear_on_a = is_pwm ? ctrl1.period_duty_swap_bit : ctrl1.clear_select_bit;
    clr = clear_on_a ? a_hit : p_hit;
    set_p = p_hit & (is_pwm | ~ctrl1.clear_select_bit);
    next_en_q = ctrl0.timer_enable_bit;
    if (en_rise) begin
      next_cnt = `CTCP_CNT_RST;
    end else if (run) begin
      next_cnt = clr ? `CTCP_CNT_RST : cnt_inc;
    end else begin
      next_cnt = cnt;
    end
  end

  // pwm waveform; lengths are one bit wider so 1024 fits
  always_comb begin
    code_len = code_zero ? `CTCP_FULL_LEN : {1'b0, ctrl0.period_code, 7'h00};
    cmpa_len = (cmpa == 10'h000) ? `CTCP_FULL_LEN : {1'b0, cmpa};
    duty_len = ctrl1.period_duty_swap_bit ? code_len : {1'b0, cmpa};
    period_len = ctrl1.period_duty_swap_bit ? cmpa_len : code_len;
    // counter never reaches the period, so duty at or above it stays active
    pwm_active = ({1'b0, cnt} < duty_len);
    unique case (ctrl1.pin_action)
      2'h1: pwm_lvl = ctrl1.output_control_bit;
      2'h2: pwm_lvl = pwm_active ? ctrl1.output_control_bit
                                 : ~ctrl1.output_control_bit;
      default: pwm_lvl = ~ctrl1.output_control_bit;
    endcase
  end

  // compare-mode pin level and pin drive
  always_comb begin
    next_pin_lvl = pin_lvl;
    if (en_rise) begin
      next_pin_lvl = ctrl1.output_control_bit;
    end else if (is_cmp & a_hit) begin
      unique case (ctrl1.pin_action)
        2'h1: next_pin_lvl = 1'b0;
        2'h2: next_pin_lvl = 1'b1;
        2'h3: next_pin_lvl = ~pin_lvl;
        default: next_pin_lvl = pin_lvl;
      endcase
    end
    out_lvl = is_pwm ? pwm_lvl : pin_lvl;
    next_pin_out = pin_used & (out_lvl ^ ctrl1.output_invert_bit);
    next_pin_oe = pin_used;
  end

  // register writes and flag updates; a set beats a same-cycle clear
  always_comb begin
    next_ctrl0 = ctrl0;
    next_ctrl1 = ctrl1;
    next_cmpa = cmpa;
    next_flag_a = flag_a;
    next_flag_p = flag_p;
    if (wr & i_pstrb[0]) begin
      unique case (i_paddr)
        `CTCP_OFS_CTRL0: next_ctrl0 = ctcp_ctrl0_t'(i_pwdata[7:0]);
        `CTCP_OFS_CTRL1: next_ctrl1 = ctcp_ctrl1_t'(i_pwdata[7:0]);
        `CTCP_OFS_CMPA_LO: next_cmpa[7:0] = i_pwdata[7:0];
        `CTCP_OFS_CMPA_HI: next_cmpa[9:8] = i_pwdata[1:0];
        `CTCP_OFS_FLAGS: begin
          if (i_pwdata[`CTCP_FLAG_A_BIT]) next_flag_a = 1'b0;
          if (i_pwdata[`CTCP_FLAG_P_BIT]) next_flag_p = 1'b0;
        end
        default: next_ctrl0 = ctrl0;
      endcase
    end
    if (a_hit) next_flag_a = 1'b1;
    if (set_p) next_flag_p = 1'b1;
  end

  // read data captured in the setup cycle, shown in the access cycle
  always_comb begin
    next_prdata = prdata;
    if (rd_setup) begin
      unique case (i_paddr)
        `CTCP_OFS_CTRL0: next_prdata = {24'h000000, ctrl0};
        `CTCP_OFS_CTRL1: next_prdata = {24'h000000, ctrl1};
        `CTCP_OFS_CNT_LO: next_prdata = {24'h000000, cnt[7:0]};
        `CTCP_OFS_CNT_HI: next_prdata = {30'h00000000, cnt[9:8]};
        `CTCP_OFS_CMPA_LO: next_prdata = {24'h000000, cmpa[7:0]};
        `CTCP_OFS_CMPA_HI: next_prdata = {30'h00000000, cmpa[9:8]};
        `CTCP_OFS_FLAGS: next_prdata = {30'h00000000, flag_p, flag_a};
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  // all state registers
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0 <= ctcp_ctrl0_t'(`CTCP_CTRL0_RST);
      ctrl1 <= ctcp_ctrl1_t'(`CTCP_CTRL1_RST);
      cnt <= `CTCP_CNT_RST;
      cmpa <= `CTCP_CMPA_RST;
      en_q <= 1'b0;
      pin_lvl <= 1'b0;
      flag_a <= 1'b0;
      flag_p <= 1'b0;
      prdata <= 32'h00000000;
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
      a_pulse <= 1'b0;
      p_pulse <= 1'b0;
    end else begin
      ctrl0 <= next_ctrl0;
      ctrl1 <= next_ctrl1;
      cnt <= next_cnt;
      cmpa <= next_cmpa;
      en_q <= next_en_q;
      pin_lvl <= next_pin_lvl;
      flag_a <= next_flag_a;
      flag_p <= next_flag_p;
      prdata <= next_prdata;
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
      a_pulse <= a_hit;
      p_pulse <= set_p;
    end
  end

  assign o_prdata = prdata;
  assign o_timer_output_pin = pin_out;
  assign o_timer_output_pin_oe = pin_oe;
  assign o_compare_a_match = a_pulse;
  assign o_compare_p_match = p_pulse;

  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_enable_rise;
    !en_q && ctrl0.timer_enable_bit;
  endsequence

  sequence s_count_from_zero;
    (cnt == 10'h000) ##1 (cnt <= 10'h001);
  endsequence

  en_rise_zero_a: assert property (s_enable_rise |=> s_count_from_zero)
    else $error("counter not zeroed after enable rise");
  en_low_hold_a: assert property (!ctrl0.timer_enable_bit |=> cnt == $past(cnt))
    else $error("counter moved while disabled");
  clr_on_a_a: assert property (a_hit && clear_on_a && !en_rise |=> cnt == 10'h000)
    else $error("counter not cleared on compare A match");
  no_p_flag_a: assert property (!is_pwm && ctrl1.clear_select_bit |=> !o_compare_p_match)
    else $error("P flag raised with clear-select set");
  zero_cmpa_flag_a: assert property (cmpa == 10'h000 |=> !o_compare_a_match)
    else $error("A flag raised with zero compare value");
  tc_pin_free_a: assert property (ctrl1.mode == CTCP_MODE_TMR |=> !o_timer_output_pin_oe)
    else $error("pin driven in timer/counter mode");
  cmp_invert_a: assert property (is_cmp |=>
    o_timer_output_pin == ($past(pin_lvl) ^ $past(ctrl1.output_invert_bit)))
    else $error("compare pin polarity wrong");
  p_keeps_pin_a: assert property (is_cmp && p_hit && !a_hit && !en_rise |=>
    pin_lvl == $past(pin_lvl))
    else $error("P match moved the pin");
  forced_active_a: assert property (is_pwm && ctrl1.pin_action == 2'h1 |=>
    o_timer_output_pin == ($past(ctrl1.output_control_bit) ^ $past(ctrl1.output_invert_bit)))
    else $error("forced active pwm level wrong");
  full_duty_a: assert property (
    is_pwm && ctrl1.pin_action == 2'h2 && duty_len >= period_len
    |=> o_timer_output_pin == ($past(ctrl1.output_control_bit)
                               ^ $past(ctrl1.output_invert_bit)))
    else $error("full duty pwm not held active");
  p_top_bits_a: assert property (
    p_hit && !code_zero |=> cnt[6:0] == 7'h00 || cnt == 10'h000)
    else $error("P match off a 128 boundary");

  // flags, pwm clearing and pin levels; a set must beat a same-cycle clear
  a_flag_set_a: assert property (a_hit |=> flag_a)
    else $error("A flag not set on match");
  p_flag_cmp_a: assert property (
    is_cmp && !ctrl1.clear_select_bit && p_hit |=> flag_p)
    else $error("P flag not set in compare mode");
  pwm_p_clear_a: assert property (
    is_pwm && !ctrl1.period_duty_swap_bit && p_hit |=> cnt == 10'h000)
    else $error("pwm counter not cleared by period code");
  pwm_a_clear_a: assert property (
    is_pwm && ctrl1.period_duty_swap_bit && a_hit |=> cnt == 10'h000)
    else $error("pwm counter not cleared by compare A");
  forced_inactive_a: assert property (
    is_pwm && ctrl1.pin_action == 2'h0 |=> o_timer_output_pin ==
    (!$past(ctrl1.output_control_bit) ^ $past(ctrl1.output_invert_bit)))
    else $error("forced inactive pwm level wrong");
  pwm_wave_a: assert property (
    is_pwm && ctrl1.pin_action == 2'h2 |=> o_timer_output_pin ==
    (($past(pwm_active) ~^ $past(ctrl1.output_control_bit)) ^ $past(ctrl1.output_invert_bit)))
    else $error("pwm waveform level wrong");
  forced_runs_a: assert property (
    is_pwm && ctrl1.pin_action != 2'h2 && run && !clr |=> cnt == $past(cnt) + 10'h001)
    else $error("pwm counter stalled while pin forced");
  cmp_initial_a: assert property (
    is_cmp && en_rise |=> pin_lvl == $past(ctrl1.output_control_bit))
    else $error("initial pin level not loaded");
  tick_hold_a: assert property (!i_timer_tick && !en_rise |=> cnt == $past(cnt))
    else $error("counter moved without a timer tick");

endmodule : ctcp_timer

// ### test/compact_timer_compare_pwm_tb_top.sv
`timescale 1ns/1ps
`include "ctcp_regs.svh"

module compact_timer_compare_pwm_tb_top import ctcp_pkg::*;;
  // bench drives every design input
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h00000000;
  logic [3:0] i_pstrb = 4'hF;
  logic i_timer_tick = 1'b1;
  logic tick_half = 1'b0;
  // design outputs
  logic [31:0] o_prdata;
  logic o_pready;
  logic o_pslverr;
  logic o_timer_output_pin;
  logic o_timer_output_pin_oe;
  logic o_compare_a_match;
  logic o_compare_p_match;
  // counters and scratch
  int errors = 0;
  int n_tests = 0;
  int na;
  int np;
  int nh;
  int noe;
  logic [31:0] rd;
  logic [31:0] v1;
  logic er;

  ctcp_timer u_dut (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_timer_tick(i_timer_tick), .o_timer_output_pin(o_timer_output_pin),
    .o_timer_output_pin_oe(o_timer_output_pin_oe),
    .o_compare_a_match(o_compare_a_match), .o_compare_p_match(o_compare_p_match)
  );

  // 100 mhz clock
  always #5 i_sys_clk = ~i_sys_clk;

  // tick every cycle, or every other cycle to prove the tick gates counting
  always @(posedge i_sys_clk) begin
    i_timer_tick <= tick_half ? ~i_timer_tick : 1'b1;
  end

  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t %s got %0h want %0h", $time, what, got, exp);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= {24'h000000, d};
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    @(posedge i_sys_clk);
    while (o_pready !== 1'b1) begin
      n++;
      if (n > 50) begin
        errors++;
        $display("FAIL %0t bus answer missing", $time);
        stop_test();
      end
      @(posedge i_sys_clk);
    end
    q = o_prdata;
    er = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d, rd);
  endtask : wr

  task rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00, rd);
    chk(rd, exp, "read back");
  endtask : rchk

  function automatic ctcp_ctrl1_t mk(ctcp_mode_t m, logic [1:0] act, logic oc, logic inv,
                                     logic sw, logic clr);
    return '{mode: m, pin_action: act, output_control_bit: oc, output_invert_bit: inv,
             period_duty_swap_bit: sw, clear_select_bit: clr};
  endfunction : mk

  // configure with the timer off, then raise enable so the counter restarts
  task cfg(input ctcp_ctrl1_t c1, input logic [2:0] code, input logic [9:0] cmpa);
    ctcp_ctrl0_t c0;
    c0 = '{spare: 4'h0, timer_enable_bit: 1'b0, period_code: code};
    wr(`CTCP_OFS_CTRL0, c0);
    wr(`CTCP_OFS_CTRL1, c1);
    wr(`CTCP_OFS_CMPA_LO, cmpa[7:0]);
    wr(`CTCP_OFS_CMPA_HI, {6'h00, cmpa[9:8]});
    wr(`CTCP_OFS_FLAGS, 8'h03);
    c0.timer_enable_bit = 1'b1;
    wr(`CTCP_OFS_CTRL0, c0);
    repeat (4) @(posedge i_sys_clk);
  endtask : cfg

  // windows span whole periods, so counts do not depend on phase
  task meas(input int n);
    na = 0;
    np = 0;
    nh = 0;
    noe = 0;
    repeat (n) begin
      @(posedge i_sys_clk);
      #1;
      if (o_compare_a_match === 1'b1) na++;
      if (o_compare_p_match === 1'b1) np++;
      if (o_timer_output_pin === 1'b1) nh++;
      if (o_timer_output_pin_oe === 1'b1) noe++;
    end
  endtask : meas

  task t_regs;
    logic [7:0] ofs [7];
    ofs = '{`CTCP_OFS_CTRL0, `CTCP_OFS_CTRL1, `CTCP_OFS_CNT_LO, `CTCP_OFS_CNT_HI,
            `CTCP_OFS_CMPA_LO, `CTCP_OFS_CMPA_HI, `CTCP_OFS_FLAGS};
    foreach (ofs[i]) rchk(ofs[i], 32'h00000000);
    wr(`CTCP_OFS_CMPA_LO, 8'hA5);
    wr(`CTCP_OFS_CMPA_HI, 8'hFF);
    rchk(`CTCP_OFS_CMPA_LO, 32'h000000A5);
    rchk(`CTCP_OFS_CMPA_HI, 32'h00000003);
    rchk(8'h1C, 32'h00000000);
    chk(er, 1'b1, "unmapped error");
    $display("test regs done");
  endtask : t_regs

  task t_cmp_a;
    cfg(mk(CTCP_MODE_CMP, 2'h3, 1'b1, 1'b0, 1'b0, 1'b1), 3'h1, 10'h014);
    chk(o_timer_output_pin, 1'b1, "initial level");
    meas(400);
    chk(na, 20, "a pulses");
    chk(np, 0, "p pulses");
    chk(nh, 200, "toggle duty");
    chk(noe, 400, "pin driven");
    rchk(`CTCP_OFS_FLAGS, 32'h00000001);
    cfg(mk(CTCP_MODE_CMP, 2'h0, 1'b1, 1'b0, 1'b0, 1'b1), 3'h1, 10'h014);
    meas(400);
    chk(nh, 400, "no change action");
    $display("test compare a done");
  endtask : t_cmp_a

  task t_cmp_p;
    cfg(mk(CTCP_MODE_CMP, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0), 3'h1, 10'h005);
    meas(256);
    chk(na, 2, "a pulses");
    chk(np, 2, "p pulses");
    rchk(`CTCP_OFS_FLAGS, 32'h00000003);
    chk(nh, 128, "pin on a only");
    $display("test compare p done");
  endtask : t_cmp_p

  task t_ovf;
    cfg(mk(CTCP_MODE_CMP, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0), 3'h0, 10'h000);
    meas(2048);
    chk(na, 0, "no a flag");
    chk(np, 2, "overflow period");
    rchk(`CTCP_OFS_FLAGS, 32'h00000002);
    wr(`CTCP_OFS_CTRL0, 8'h00);
    apb(1'b0, `CTCP_OFS_CNT_LO, 8'h00, v1);
    wr(`CTCP_OFS_CNT_LO, 8'h00);
    repeat (20) @(posedge i_sys_clk);
    rchk(`CTCP_OFS_CNT_LO, v1);
    apb(1'b0, `CTCP_OFS_CNT_HI, 8'h00, rd);
    chk(rd[31:2], 30'h00000000, "high byte top");
    $display("test overflow done");
  endtask : t_ovf

  task t_tmr;
    tick_half <= 1'b1;
    cfg(mk(CTCP_MODE_TMR, 2'h3, 1'b1, 1'b1, 1'b0, 1'b1), 3'h1, 10'h003);
    meas(60);
    chk(na, 10, "ticked a pulses");
    chk(noe, 0, "pin released");
    chk(nh, 0, "pin low");
    tick_half <= 1'b0;
    $display("test timer done");
  endtask : t_tmr

  task t_pwm;
    cfg(mk(CTCP_MODE_PWM, 2'h2, 1'b1, 1'b0, 1'b0, 1'b1), 3'h1, 10'h020);
    meas(256);
    chk(nh, 64, "duty from a");
    chk(na, 2, "a pulses");
    chk(np, 2, "p pulses");
    cfg(mk(CTCP_MODE_PWM, 2'h2, 1'b1, 1'b1, 1'b0, 1'b0), 3'h1, 10'h020);
    meas(256);
    chk(nh, 192, "inverted");
    cfg(mk(CTCP_MODE_PWM, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0), 3'h1, 10'h020);
    meas(256);
    chk(nh, 192, "active low");
    cfg(mk(CTCP_MODE_PWM, 2'h2, 1'b1, 1'b0, 1'b1, 1'b0), 3'h1, 10'h064);
    meas(200);
    chk(nh, 200, "full duty");
    chk(na, 2, "period from a");
    cfg(mk(CTCP_MODE_PWM, 2'h0, 1'b1, 1'b0, 1'b0, 1'b0), 3'h1, 10'h020);
    meas(256);
    chk(nh, 0, "forced inactive");
    chk(np, 2, "runs while forced");
    cfg(mk(CTCP_MODE_PWM, 2'h1, 1'b1, 1'b0, 1'b0, 1'b0), 3'h1, 10'h020);
    meas(256);
    chk(nh, 256, "forced active");
    chk(na, 2, "runs while forced");
    $display("test pwm done");
  endtask : t_pwm

  // reset held three cycles, first transfer after the internal release
  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_nrst <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    t_regs();
    t_cmp_a();
    t_cmp_p();
    t_ovf();
    t_tmr();
    t_pwm();
    stop_test();
  end
endmodule : compact_timer_compare_pwm_tb_top
